// ### logic/nvpec_cfg.svh
// Offsets, field positions, reset values and timing counts of the array sequencer
`ifndef NVPEC_CFG_SVH
`define NVPEC_CFG_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define NVPEC_OFF_CTRL 12'h000
`define NVPEC_OFF_CFG 12'h004
`define NVPEC_OFF_NVCFG 12'h008
`define NVPEC_OFF_ARRAY 12'h800
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define NVPEC_CTRL_HVE 0
`define NVPEC_CTRL_LAT 1
`define NVPEC_CTRL_ERS0 2
`define NVPEC_CTRL_ERS1 3
`define NVPEC_CTRL_AUTO 4
`define NVPEC_CTRL_PWD 5
// ----------------------------------------
// Array map and reset values
// ----------------------------------------
`define NVPEC_ARRAY_BASE 16'h0800
`define NVPEC_ARRAY_LAST 16'h09FF
`define NVPEC_SEC_LO 16'h08F0
`define NVPEC_SEC_HI 16'h08FF
`define NVPEC_NVCFG_RESET 8'hF0
`define NVPEC_CTRL_RESET 8'h00
`define NVPEC_ERASED 8'hFF
// ----------------------------------------
// Timing
// ----------------------------------------
`define NVPEC_CLK_MHZ 200
`define NVPEC_AUTO_US 1
`define NVPEC_AUTO_CYC (`NVPEC_AUTO_US * `NVPEC_CLK_MHZ)
`define NVPEC_FALL_US 1
`define NVPEC_FALL_CYC (`NVPEC_FALL_US * `NVPEC_CLK_MHZ)
`endif

// ### logic/nvpec_pkg.sv
// Types shared by the array sequencer
package nvpec_pkg;
   typedef enum logic [1:0] {
      OP_PROG = 2'h0,
      OP_BYTE_ERASE = 2'h1,
      OP_BLOCK_ERASE = 2'h2,
      OP_BULK_ERASE = 2'h3
   } nvpec_op_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PULSE = 3'b010,
      ST_PAUSE = 3'b100
   } nvpec_state_t;
   typedef struct packed {
      logic spare;
      logic zero;
      logic pwd;
      logic auto;
      logic ers1;
      logic ers0;
      logic lat;
      logic hve;
   } nvpec_ctrl_t;
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] data;
   } nvpec_capture_t;
endpackage

// ### logic/nvpec_ctrl.sv
// Program/erase sequencer for the nonvolatile byte array, AXI4-Lite slave
`timescale 1ns/1ps
`include "nvpec_cfg.svh"

module nvpec_ctrl (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   // Low-power stop request
   input wire logic stopReq,
   // Status
   output logic pumpOn,
   output logic seqBusy,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [7:0] mem [0:511];
   nvpec_pkg::nvpec_ctrl_t ctrl;
   logic [7:0] cfg;
   logic [7:0] nvCfg = `NVPEC_NVCFG_RESET;
   nvpec_pkg::nvpec_capture_t cap;
   logic capValid;
   logic capIsCfg;
   nvpec_pkg::nvpec_state_t state;
   logic [15:0] timer;
   logic stopS1, stopS2;
   logic [11:0] awAddr;
   logic awHave;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic wHave;

   // Whether a byte address falls at or above the array base
   function automatic logic inArray(input logic [11:0] a);
      inArray = a >= `NVPEC_OFF_ARRAY;
   endfunction
   // Guard bit covering an array byte
   function automatic logic guarded(input logic [8:0] a, input logic [3:0] g);
      guarded = g[a[8:7]];
   endfunction
   // Byte within the secured range at array offsets 0xF0 to 0xFF
   function automatic logic secured(input logic [8:0] a);
      secured = ({7'h04, a} >= `NVPEC_SEC_LO) && ({7'h04, a} <= `NVPEC_SEC_HI);
   endfunction

   // ----------------------------------------
   // Synchroniser for the stop request pin
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stopS1 <= 1'b0;
         stopS2 <= 1'b0;
      end else if (clkEn) begin
         stopS1 <= stopReq;
         stopS2 <= stopS1;
      end
   end

   // ----------------------------------------
   // Write channel acceptance
   // ----------------------------------------
   // Address and data are held separately so they may arrive in either order
   wire doWrite = awHave && wHave && !s_axi_bvalid;
   assign s_axi_awready = !awHave && rst_n;
   assign s_axi_wready = !wHave && rst_n;
   wire [11:0] wAddrWord = {awAddr[11:2], 2'b00};
   wire wArray = inArray(wAddrWord) && wStrb[0];
   // One byte per word, so the word index is the byte index
   wire [8:0] wOff = wAddrWord[10:2];
   wire wCtrl = (wAddrWord == `NVPEC_OFF_CTRL) && wStrb[0];
   wire wCfg = (wAddrWord == `NVPEC_OFF_CFG) && wStrb[0];
   wire wNv = (wAddrWord == `NVPEC_OFF_NVCFG) && wStrb[0];
   wire wMapped = inArray(wAddrWord) || (wAddrWord == `NVPEC_OFF_CTRL)
      || (wAddrWord == `NVPEC_OFF_CFG) || (wAddrWord == `NVPEC_OFF_NVCFG);
   wire [7:0] wByte = wData[7:0];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         awHave <= 1'b0;
         wHave <= 1'b0;
         awAddr <= 12'h000;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (clkEn) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wMapped ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Read channel decode
   // ----------------------------------------
   assign s_axi_arready = !s_axi_rvalid && rst_n;
   wire doRead = s_axi_arvalid && s_axi_arready;
   wire [11:0] rAddrWord = {s_axi_araddr[11:2], 2'b00};
   wire rArray = inArray(rAddrWord);
   wire [8:0] rOff = rAddrWord[10:2];
   wire rNv = rAddrWord == `NVPEC_OFF_NVCFG;
   wire rMapped = rArray || rNv || (rAddrWord == `NVPEC_OFF_CTRL)
      || (rAddrWord == `NVPEC_OFF_CFG);
   // Array reads during a sequence or power-down are refused, the array is busy or off
   wire arrBlocked = (state != nvpec_pkg::ST_IDLE) || ctrl.pwd;
   wire [7:0] arrRead = ctrl.lat ? cap.data : mem[rOff];
   wire [7:0] rByte = rArray ? arrRead :
      rNv ? nvCfg :
      (rAddrWord == `NVPEC_OFF_CTRL) ? ctrl :
      (rAddrWord == `NVPEC_OFF_CFG) ? cfg : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (clkEn) begin
         if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, (rArray && arrBlocked) ? 8'h00 : rByte};
            s_axi_rresp <= (!rMapped || (rArray && arrBlocked)) ? 2'h2 : 2'h0;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Operation permission
   // ----------------------------------------
   wire [3:0] guardBits = cfg[3:0];
   wire secOn = !cfg[4];
   wire [1:0] opSel = {ctrl.ers1, ctrl.ers0};
   // Mode selection from the erase selects
   wire isProg = opSel == nvpec_pkg::OP_PROG;
   wire isBlock = opSel == nvpec_pkg::OP_BLOCK_ERASE;
   wire isBulk = opSel == nvpec_pkg::OP_BULK_ERASE;
   // Secured range, block erases and bulk erases refused under security
   wire opAllowed = capIsCfg ? !secOn :
      !((isBlock || isBulk) && secOn) && !(secOn && secured(cap.addr));
   // Target byte, block or whole array hit when its block is unguarded
   function automatic logic hits(input logic [8:0] a, input logic [8:0] t,
      input logic [1:0] op, input logic [3:0] g, input logic s);
      logic same;
      same = (op == 2'h3) || ((op == 2'h2) ? (a[8:7] == t[8:7]) : (a == t));
      hits = same && !guarded(a, g) && !(s && secured(a));
   endfunction

   // ----------------------------------------
   // Control register and capture
   // ----------------------------------------
   wire [7:0] ctrlIn = wByte;
   // Control writes held off while armed and nothing captured
   wire ctrlOk = wCtrl && doWrite && !(ctrl.lat && !capValid);
   // Pump set only with latch and a valid capture
   wire hveSetOk = ctrlIn[`NVPEC_CTRL_HVE] && ctrl.lat && capValid && opAllowed
      && !ctrl.pwd;
   // Auto pulse ends well inside the specified program or erase time
   wire autoDone = (state == nvpec_pkg::ST_PULSE) && ctrl.auto
      && (timer == 16'(`NVPEC_AUTO_CYC - 1));

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl <= `NVPEC_CTRL_RESET;
         cap <= '0;
         capValid <= 1'b0;
         capIsCfg <= 1'b0;
      end else if (clkEn) begin
         if (ctrlOk) begin
            ctrl.spare <= ctrlIn[7];
            ctrl.pwd <= ctrlIn[`NVPEC_CTRL_PWD];
            ctrl.auto <= ctrlIn[`NVPEC_CTRL_AUTO];
            ctrl.ers1 <= ctrlIn[`NVPEC_CTRL_ERS1];
            ctrl.ers0 <= ctrlIn[`NVPEC_CTRL_ERS0];
            // Latch held while pump was set
            ctrl.lat <= ctrlIn[`NVPEC_CTRL_LAT] || ctrl.hve;
            ctrl.hve <= ctrl.hve ? ctrlIn[`NVPEC_CTRL_HVE] : hveSetOk;
            if (!ctrlIn[`NVPEC_CTRL_LAT] && !ctrl.hve) begin
               capValid <= 1'b0;
            end
         end else if (autoDone) begin
            // Auto timer clears the pump bit
            ctrl.hve <= 1'b0;
         end
         // Valid array writes replace the capture
         if (ctrl.lat && !ctrl.hve && doWrite && (wArray || wNv)) begin
            cap.addr <= wOff;
            cap.data <= wByte;
            capValid <= 1'b1;
            capIsCfg <= wNv;
         end else if (ctrl.lat && !ctrl.hve && doRead && rArray) begin
            cap.addr <= rOff;
            capValid <= 1'b1;
            capIsCfg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Sequencer: pulse, stop pause and commit
   // ----------------------------------------
   // The array changes when a pulse in ST_PULSE ends; one abandoned in ST_PAUSE leaves data intact unless stopS2 is low then, which resumes ST_PULSE
   wire pulseEnd = (state == nvpec_pkg::ST_PULSE) && !ctrl.hve;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= nvpec_pkg::ST_IDLE;
         timer <= 16'h0000;
      end else if (clkEn) begin
         case (state)
            nvpec_pkg::ST_IDLE: begin
               timer <= 16'h0000;
               if (ctrl.hve && !stopS2) begin
                  state <= nvpec_pkg::ST_PULSE;
               end
            end
            nvpec_pkg::ST_PULSE: begin
               timer <= timer + 16'h0001;
               if (stopS2 && ctrl.hve) begin
                  state <= nvpec_pkg::ST_PAUSE;
               end else if (pulseEnd) begin
                  state <= nvpec_pkg::ST_IDLE;
               end
            end
            nvpec_pkg::ST_PAUSE: begin
               timer <= 16'h0000;
               if (!stopS2) begin
                  state <= nvpec_pkg::ST_PULSE;
               end else if (!ctrl.hve) begin
                  state <= nvpec_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= nvpec_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Commit: programming ANDs, erasing sets ones, guarded bytes skipped
   always_ff @(posedge clk_sys) begin
      if (clkEn && pulseEnd && !capIsCfg) begin
         for (int i = 0; i < 512; i++) begin
            if (hits(9'(i), cap.addr, isProg ? 2'h0 : opSel, guardBits, secOn)) begin
               mem[i] <= isProg ? (mem[i] & cap.data) : `NVPEC_ERASED;
            end
         end
      end
   end

   // ----------------------------------------
   // Configuration byte and configuration register
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         // Reset value loads on each clock edge while reset is held
         cfg <= `NVPEC_NVCFG_RESET;
      end else if (clkEn) begin
         if (doRead && rNv) begin
            // Reading the config byte refreshes guards and security
            cfg <= {cfg[7:5], nvCfg[4] & cfg[4], nvCfg[3:0]};
         end else if (doWrite && wCfg) begin
            cfg[7:5] <= wByte[7:5];
         end
      end
   end

   // Config byte persists across reset, as nonvolatile storage
   always_ff @(posedge clk_sys) begin
      if (clkEn && pulseEnd && capIsCfg && !secOn) begin
         nvCfg <= isProg ? (nvCfg & cap.data) : `NVPEC_ERASED;
      end
   end
   assign pumpOn = ctrl.hve && (state == nvpec_pkg::ST_PULSE);
   assign seqBusy = state != nvpec_pkg::ST_IDLE;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   latch_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $past(ctrl.hve) && $past(clkEn) |-> ctrl.lat)
      else $error("latch cleared while pump set");
   pump_guard_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(ctrl.hve) |-> $past(ctrl.lat) && $past(capValid))
      else $error("pump set without capture");
   auto_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      autoDone && clkEn && !ctrlOk |=> !ctrl.hve)
      else $error("auto did not clear pump");
   auto_short_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == nvpec_pkg::ST_PULSE |-> timer <= 16'(`NVPEC_AUTO_CYC) || !ctrl.auto)
      else $error("auto pulse too long");
   capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clkEn && ctrl.lat && !ctrl.hve && doWrite && wArray |=> cap.data == $past(wByte))
      else $error("capture not replaced");
   single_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clkEn && ctrlOk && ctrl.hve && ctrlIn[1:0] == 2'b00 |=> ctrl.lat && !ctrl.hve)
      else $error("double clear dropped latch");
   secure_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !cfg[4] |=> !cfg[4])
      else $error("security disabled");
   pause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == nvpec_pkg::ST_PAUSE |-> !pumpOn)
      else $error("pump on during stop");
   start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      clkEn && ctrl.hve && state == nvpec_pkg::ST_IDLE && !stopS2
      |=> state == nvpec_pkg::ST_PULSE)
      else $error("sequence not started");
   prog_c: cover property (@(posedge clk_sys) pulseEnd && isProg);
   erase_c: cover property (@(posedge clk_sys) pulseEnd && isBlock);
   stop_c: cover property (@(posedge clk_sys) state == nvpec_pkg::ST_PAUSE);
endmodule

// ### sim/nvpec_host.sv
// Host-side AXI4-Lite master model that software uses to reach the sequencer
`timescale 1ns/1ps

module nvpec_host (
   // Clock
   input wire logic clk_sys,
   // AXI4-Lite master
   output logic [11:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [11:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // ----------------------------------------
   // Idle state
   // ----------------------------------------
   initial begin
      s_axi_awaddr = 12'h000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 12'h000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end

   // One write: each channel is released right after the rising edge that takes it
   task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      logic tb;
      tb = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!tb) begin
         @(posedge clk_sys);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            tb = 1'b1;
            r = s_axi_bresp;
         end
      end
      s_axi_bready <= 1'b0;
   endtask

   // One read, same sampling scheme
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic tr;
      tr = 1'b0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!tr) begin
         @(posedge clk_sys);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            tr = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
      end
      s_axi_rready <= 1'b0;
   endtask
endmodule

// ### sim/eeprom_program_erase_control_test.sv
// Self-checking bench of the array sequencer with a reference array model
`timescale 1ns/1ps
`include "nvpec_cfg.svh"

module eeprom_program_erase_control_test;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic stopReq = 1'b0;
   logic pumpOn, seqBusy, awready, awvalid, wready, wvalid, bvalid, bready;
   logic arready, arvalid, rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int nMismatch = 0;
   int checked = 0;
   int mem [512];
   logic [31:0] seed = 32'hd47c11af;

   initial forever #2.5 clk_sys = ~clk_sys;

   nvpec_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1), .stopReq(stopReq),
      .pumpOn(pumpOn), .seqBusy(seqBusy), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   nvpec_host u_host (.clk_sys(clk_sys), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] rnd8();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   function automatic logic [11:0] aa(input int i);
      return `NVPEC_OFF_ARRAY + 12'(i * 4);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         nMismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrc(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic [1:0] r;
      u_host.wr(a, d, r);
      chk(32'(r), 32'(er));
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      u_host.rd(a, d, r);
      chk(32'(r), 32'(er));
      chk(d, e);
   endtask

   // One program or erase pass; a decoy array write first is replaced by the real one
   task automatic op(input int ers, input int i, input logic [7:0] d, input bit au,
         input bit stp);
      logic [7:0] c;
      logic [31:0] v;
      logic [1:0] r;
      int n;
      c = 8'(ers * 4 + 2 + (au ? 16 : 0));
      wrc(`NVPEC_OFF_CTRL, c, 2'h0);
      wrc(aa(i ^ 5), rnd8(), 2'h0);
      wrc(aa(i), d, 2'h0);
      rdc(aa(i), 32'(d), 2'h0);
      wrc(`NVPEC_OFF_CTRL, c | 8'h01, 2'h0);
      #1 chk(32'(pumpOn), 32'h1);
      if (stp) begin
         repeat (20) @(posedge clk_sys);
         stopReq <= 1'b1;
         repeat (10) @(posedge clk_sys);
         chk(32'({pumpOn, seqBusy}), 32'h1);
         stopReq <= 1'b0;
      end
      if (au) begin
         // Control reads are safe while the pump runs; array reads are not
         n = 0;
         v = 32'h1;
         while (v[0] === 1'b1 && n < 300) begin
            u_host.rd(`NVPEC_OFF_CTRL, v, r);
            n++;
         end
         chk(v, 32'(c));
      end else begin
         repeat (250) @(posedge clk_sys);
         wrc(`NVPEC_OFF_CTRL, c & 8'hFC, 2'h0);
         rdc(`NVPEC_OFF_CTRL, 32'(c), 2'h0);
         repeat (`NVPEC_FALL_CYC) @(posedge clk_sys);
      end
      wrc(`NVPEC_OFF_CTRL, 8'h00, 2'h0);
      rdc(`NVPEC_OFF_CTRL, 32'h0, 2'h0);
      for (int k = 0; k < 512; k++) begin
         if ((ers == 0 && k == i) ) mem[k] = mem[k] & d;
         if ((ers == 1 && k == i) || (ers == 2 && k / 128 == i / 128) || ers == 3)
            mem[k] = 8'hFF;
      end
      foreach (mem[k]) begin
         if (k % 37 == 0 || k == i || k == (i ^ 5))
            rdc(aa(k), mem[k], 2'h0);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, nMismatch);
      if (nMismatch == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdc(`NVPEC_OFF_CTRL, 32'h0, 2'h0);
      rdc(`NVPEC_OFF_CFG, 32'hF0, 2'h0);
      rdc(`NVPEC_OFF_NVCFG, 32'hF0, 2'h0);
      wrc(`NVPEC_OFF_CFG, 8'hFF, 2'h0);
      rdc(`NVPEC_OFF_CFG, 32'hF0, 2'h0);
      wrc(`NVPEC_OFF_CFG, 8'h0F, 2'h0);
      rdc(`NVPEC_OFF_CFG, 32'h10, 2'h0);
      wrc(`NVPEC_OFF_CTRL, 8'h80, 2'h0);
      rdc(`NVPEC_OFF_CTRL, 32'h80, 2'h0);
      wrc(`NVPEC_OFF_CTRL, 8'h01, 2'h0);
      rdc(`NVPEC_OFF_CTRL, 32'h0, 2'h0);
      // Latch armed, nothing captured: an unmapped write must not count as capture
      wrc(`NVPEC_OFF_CTRL, 8'h02, 2'h0);
      wrc(12'h00C, rnd8(), 2'h2);
      wrc(`NVPEC_OFF_CTRL, 8'h03, 2'h0);
      rdc(`NVPEC_OFF_CTRL, 32'h2, 2'h0);
      wrc(aa(3), rnd8(), 2'h0);
      wrc(`NVPEC_OFF_CTRL, 8'h00, 2'h0);
      rdc(`NVPEC_OFF_CTRL, 32'h0, 2'h0);
      // All four modes; the array starts unknown, so bulk erase comes first
      op(3, 37, rnd8(), 1'b0, 1'b0);
      op(0, 300, rnd8(), 1'b1, 1'b1);
      op(1, 300, rnd8(), 1'b1, 1'b0);
      op(0, 200, rnd8(), 1'b1, 1'b0);
      op(2, 130, rnd8(), 1'b1, 1'b0);
      wrc(`NVPEC_OFF_CTRL, 8'h20, 2'h0);
      rdc(aa(1), 32'h0, 2'h2);
      wrc(`NVPEC_OFF_CTRL, 8'h00, 2'h0);
      conclude();
   end

   // Whole run is a few thousand cycles; far beyond that means a hang
   initial begin
      repeat (40000) @(posedge clk_sys);
      nMismatch++;
      conclude();
   end
endmodule
